/* core/rpc_sop_capture.sv */
// receive start-of-packet time capture with lane report and deskew fill levels
`timescale 1ns/1ps
//Behaviour
//- normal mode time is 48 bits seconds then 32 bits nanoseconds.
//- transparent mode: sign bit 63, nanoseconds 62:16, fraction 15:0.
//- an 80-bit timestamp is captured for every received start of packet.
//- captured timestamp keeps the exact bit layout of the time source.
//- a 5-bit index reports which of 20 lanes carried the start.
//- each of 20 lanes reports a 7-bit alignment buffer fill level.
module rpc_sop_capture #(
	parameter int SEGS = rpc_pkg::SEGS,
	parameter int LANES = rpc_pkg::LANES,
	parameter int LANE_W = rpc_pkg::LANE_W,
	parameter int FILL_W = rpc_pkg::FILL_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// time source and format
	input wire logic [rpc_pkg::TIME_W-1:0] rx_time_source_in,
	input wire logic transparentMode,
	// capture plane: per-segment start of packet and its lane
	input wire logic [SEGS-1:0] planeSop,
	input wire logic [SEGS*LANE_W-1:0] planeLane,
	// local packet bus start of packet, delivered to the client
	output logic [SEGS-1:0] busSop,
	// capture results
	output logic [rpc_pkg::TIME_W-1:0] rx_sop_time_capture,
	output logic [LANE_W-1:0] rx_sop_lane_index,
	output logic captureHeld,
	output logic captureTransparent,
	// alignment buffer events and fill levels
	input wire logic [LANES-1:0] alignWr,
	input wire logic [LANES-1:0] alignRd,
	output logic [LANES*FILL_W-1:0] lane_deskew_fill_level
);
	localparam int TW = rpc_pkg::TIME_W;

	if (SEGS < 1 || LANES < 1 || LANES > (1 << LANE_W) || FILL_W < 1) begin : gBadParams
		$error("unsupported segment, lane or fill width settings");
	end

	// lowest segment wins when several carry a start in one cycle
	function automatic logic [LANE_W-1:0] firstLane(input logic [SEGS-1:0] sop,
			input logic [SEGS*LANE_W-1:0] lanes);
		logic [LANE_W-1:0] res;
		res = rpc_pkg::LANE_RESET;
		for (int i = SEGS - 1; i >= 0; i--) begin
			if (sop[i]) begin
				res = lanes[i*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction

	function automatic logic [rpc_pkg::SEC_W-1:0] secondsOf(input logic [TW-1:0] t);
		return t[TW-1:rpc_pkg::SEC_LO];
	endfunction

	function automatic logic [rpc_pkg::NS_W-1:0] nanosOf(input logic [TW-1:0] t);
		return t[rpc_pkg::SEC_LO-1:0];
	endfunction

	function automatic logic [rpc_pkg::TC_NS_W-1:0] tcNanosOf(input logic [TW-1:0] t);
		return t[rpc_pkg::TC_NS_HI:rpc_pkg::TC_NS_LO];
	endfunction

	function automatic logic [rpc_pkg::TC_FRAC_W-1:0] tcFracOf(input logic [TW-1:0] t);
		return t[rpc_pkg::TC_FRAC_HI:0];
	endfunction

	// capture state
	rpc_pkg::rpc_cap_e state_q;
	rpc_pkg::rpc_cap_e state_d;
	logic [TW-1:0] ts_q;
	logic [TW-1:0] ts_d;
	logic [LANE_W-1:0] lane_q;
	logic [LANE_W-1:0] lane_d;
	logic [SEGS-1:0] sop_q;
	logic [SEGS-1:0] sop_d;
	logic tcMode_q;
	logic tcMode_d;
	logic anySop;

	// the register stage that launches the bus start is the capture plane,
	// so the stamp and the bus start leave on the same edge
	always_comb begin
		anySop = |planeSop;
		sop_d = planeSop;
		ts_d = ts_q;
		lane_d = lane_q;
		tcMode_d = tcMode_q;
		state_d = state_q;
		if (anySop) begin
			ts_d = rx_time_source_in;
			lane_d = firstLane(planeSop, planeLane);
			tcMode_d = transparentMode;
		end
		case (state_q)
			rpc_pkg::CAP_IDLE: begin
				if (anySop) begin
					state_d = rpc_pkg::CAP_HELD;
				end
			end
			rpc_pkg::CAP_HELD: begin
				state_d = rpc_pkg::CAP_HELD;
			end
			default: begin
				state_d = rpc_pkg::CAP_IDLE;
			end
		endcase
	end

	// time source is sampled on clk_sys, which the lane 0 serial clock must match
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= rpc_pkg::CAP_IDLE;
			ts_q <= rpc_pkg::TS_RESET;
			lane_q <= rpc_pkg::LANE_RESET;
			sop_q <= '0;
			tcMode_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ts_q <= ts_d;
			lane_q <= lane_d;
			sop_q <= sop_d;
			tcMode_q <= tcMode_d;
		end
	end

	assign busSop = sop_q;
	assign rx_sop_time_capture = ts_q;
	assign rx_sop_lane_index = lane_q;
	assign captureHeld = (state_q == rpc_pkg::CAP_HELD);
	assign captureTransparent = tcMode_q;

	// fill levels pair with the lane index for client deskew correction
	rpc_fill_if #(.LANES(LANES), .FILL_W(FILL_W)) fillBus ();

	rpc_fill_tracker #(.LANES(LANES), .FILL_W(FILL_W)) uFill (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.alignWr(alignWr),
		.alignRd(alignRd),
		.fillOut(fillBus.tracker)
	);

	assign lane_deskew_fill_level = fillBus.fill;

	sequence planeStart;
		|planeSop;
	endsequence

	sequence noStart;
		!(|planeSop);
	endsequence

	ts_capture_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		planeStart |=> rx_sop_time_capture == $past(rx_time_source_in))
		else $error("timestamp not captured at start of packet");

	sop_align_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(|busSop) |-> captureHeld && busSop == $past(planeSop)
			&& rx_sop_time_capture == $past(rx_time_source_in))
		else $error("bus start and timestamp out of step");

	layout_same_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		planeStart |=> rx_sop_time_capture == $past(rx_time_source_in)
			&& captureTransparent == $past(transparentMode))
		else $error("timestamp bit layout differs from time source");

	normal_fields_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(planeStart and !transparentMode) |=> !captureTransparent
			&& secondsOf(rx_sop_time_capture) == $past(secondsOf(rx_time_source_in))
			&& nanosOf(rx_sop_time_capture) == $past(nanosOf(rx_time_source_in)))
		else $error("seconds or nanoseconds field misplaced");

	tc_fields_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(planeStart and transparentMode) |=> captureTransparent
			&& rx_sop_time_capture[rpc_pkg::TC_SIGN_BIT]
				== $past(rx_time_source_in[rpc_pkg::TC_SIGN_BIT])
			&& tcNanosOf(rx_sop_time_capture) == $past(tcNanosOf(rx_time_source_in))
			&& tcFracOf(rx_sop_time_capture) == $past(tcFracOf(rx_time_source_in)))
		else $error("transparent clock fields misplaced");

	lane_report_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		planeStart |=> rx_sop_lane_index == $past(firstLane(planeSop, planeLane))
			&& |busSop)
		else $error("lane index not taken from first started segment");

	hold_stable_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		noStart ##0 noStart |=> $stable(rx_sop_time_capture) && $stable(rx_sop_lane_index)
			&& busSop == '0)
		else $error("capture changed without a start of packet");

	fill_route_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$past(alignWr[0] && !alignRd[0]) && $past(lane_deskew_fill_level[FILL_W-1:0]) == '0
			|-> lane_deskew_fill_level[FILL_W-1:0] == 7'h01)
		else $error("lane 0 fill level not routed out");
endmodule

/* inc/rpc_pkg.sv */
// constants and types shared by the receive start-of-packet capture block
package rpc_pkg;
	localparam int TIME_W = 80;
	localparam int SEC_W = 48;
	localparam int NS_W = 32;
	localparam int SEC_LO = 32;
	localparam int TC_SIGN_BIT = 63;
	localparam int TC_NS_HI = 62;
	localparam int TC_NS_LO = 16;
	localparam int TC_FRAC_HI = 15;
	localparam int TC_NS_W = 47;
	localparam int TC_FRAC_W = 16;
	localparam int LANES = 20;
	localparam int LANE_W = 5;
	localparam int FILL_W = 7;
	localparam int SEGS = 4;
	localparam logic [TIME_W-1:0] TS_RESET = 80'h0;
	localparam logic [LANE_W-1:0] LANE_RESET = 5'h00;
	localparam logic [FILL_W-1:0] FILL_RESET = 7'h00;
	typedef enum logic [1:0] {
		CAP_IDLE = 2'h0,
		CAP_HELD = 2'h1
	} rpc_cap_e;
endpackage

/* inc/rpc_fill_if.sv */
// carries per-lane alignment buffer fill levels from the tracker to the top
`timescale 1ns/1ps
interface rpc_fill_if #(
	parameter int LANES = rpc_pkg::LANES,
	parameter int FILL_W = rpc_pkg::FILL_W
);
	logic [LANES*FILL_W-1:0] fill;
	modport tracker (output fill);
	modport user (input fill);
endinterface

/* core/rpc_fill_tracker.sv */
// per-lane alignment buffer fill counters, in serial clock cycles
`timescale 1ns/1ps
module rpc_fill_tracker #(
	parameter int LANES = rpc_pkg::LANES,
	parameter int FILL_W = rpc_pkg::FILL_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// aligner buffer events, one bit per lane
	input wire logic [LANES-1:0] alignWr,
	input wire logic [LANES-1:0] alignRd,
	// fill levels out
	rpc_fill_if.tracker fillOut
);
	localparam logic [FILL_W-1:0] FILL_MAX = {FILL_W{1'b1}};
	localparam logic [FILL_W-1:0] FILL_RESET_V = rpc_pkg::FILL_RESET;

	if (LANES < 1 || FILL_W < 1) begin : gBadParams
		$error("unsupported lane count or fill width");
	end

	logic [LANES*FILL_W-1:0] fill_q;
	logic [LANES*FILL_W-1:0] fill_d;

	// saturates rather than wraps so a misbehaving aligner never reads as nearly empty
	function automatic logic [FILL_W-1:0] stepFill(input logic [FILL_W-1:0] cur,
			input logic wr, input logic rd);
		logic [FILL_W-1:0] res;
		res = cur;
		if (wr && !rd && cur != FILL_MAX) begin
			res = cur + 1'b1;
		end else if (rd && !wr && cur != FILL_RESET_V) begin
			res = cur - 1'b1;
		end
		return res;
	endfunction

	always_comb begin
		fill_d = fill_q;
		for (int i = 0; i < LANES; i++) begin
			fill_d[i*FILL_W +: FILL_W] = stepFill(fill_q[i*FILL_W +: FILL_W], alignWr[i],
				alignRd[i]);
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fill_q <= {LANES{rpc_pkg::FILL_RESET}};
		end else begin
			fill_q <= fill_d;
		end
	end

	assign fillOut.fill = fill_q;

	for (genvar g = 0; g < LANES; g++) begin : gChk
		fill_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
			(alignWr[g] && !alignRd[g] && fill_q[g*FILL_W +: FILL_W] != FILL_MAX)
			|=> fill_q[g*FILL_W +: FILL_W] == $past(fill_q[g*FILL_W +: FILL_W]) + 1'b1)
			else $error("lane fill did not count up on a write");
	end
endmodule

/* tb/rpc_time_client.sv */
// client timing partner: time source and skew-corrected stamp
`timescale 1ns/1ps
module rpc_time_client (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// time source control
	input wire logic loadEn,
	input wire logic [79:0] loadVal,
	input wire logic transparentMode,
	output logic [79:0] timeNow,
	// capture results from the block
	input wire logic [3:0] busSop,
	input wire logic [79:0] stamp,
	input wire logic [4:0] lane,
	input wire logic [139:0] fill,
	output logic [79:0] corrected
);
	// clk_sys stands for the lane 0 serial clock; no rollover, runs stay short
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			timeNow <= 80'h0;
		end else if (loadEn) begin
			timeNow <= loadVal;
		end else begin
			timeNow <= timeNow + (transparentMode ? 80'h32_0000 : 80'h32);
		end
	end
	always_ff @(posedge clk_sys) begin
		if (|busSop) begin
			corrected <= stamp + 80'(fill[lane*7+:7]);
		end
	end
endmodule

/* tb/tb.sv */
// self-checking bench for the start-of-packet time capture block
`timescale 1ns/1ps
module tb;
	logic clk_sys, nrst, transparentMode, loadEn, captureHeld, captureTransparent;
	logic [3:0] planeSop, busSop;
	logic [19:0] planeLane, alignWr, alignRd;
	logic [79:0] loadVal, timeNow, stamp, corrected;
	logic [4:0] laneIdx;
	logic [139:0] fill;
	int fails = 0;
	int totalChecks = 0;

	rpc_sop_capture dut (.clk_sys(clk_sys), .nrst(nrst), .rx_time_source_in(timeNow),
		.transparentMode(transparentMode), .planeSop(planeSop), .planeLane(planeLane),
		.busSop(busSop), .rx_sop_time_capture(stamp), .rx_sop_lane_index(laneIdx),
		.captureHeld(captureHeld), .captureTransparent(captureTransparent),
		.alignWr(alignWr), .alignRd(alignRd), .lane_deskew_fill_level(fill));
	rpc_time_client partner (.clk_sys(clk_sys), .nrst(nrst), .loadEn(loadEn),
		.loadVal(loadVal), .transparentMode(transparentMode), .timeNow(timeNow),
		.busSop(busSop), .stamp(stamp), .lane(laneIdx), .fill(fill),
		.corrected(corrected));

	task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic loadTime(input logic [79:0] v);
		loadVal = v;
		loadEn = 1'b1;
		step(1);
		loadEn = 1'b0;
	endtask

	task automatic capNormal;
		loadTime({48'h1234_5678_9ABC, 32'h0000_1000});
		planeSop = 4'h1;
		planeLane = 20'h00007;
		step(1);
		planeSop = 4'h0;
		chk(busSop, 4'h1);
		chk(stamp[79:32], 48'h1234_5678_9ABC);
		chk(stamp[31:0], 32'h0000_1000);
		chk(laneIdx, 5'h07);
		chk({captureHeld, captureTransparent}, 2'h2);
		step(3);
		chk(busSop, 4'h0);
		chk(stamp, {48'h1234_5678_9ABC, 32'h0000_1000});
		chk(laneIdx, 5'h07);
	endtask

	task automatic capTransparent;
		transparentMode = 1'b1;
		loadTime({16'h0, 1'b1, 47'h1234_5678, 16'hABCD});
		planeSop = 4'hC;
		planeLane = {5'h03, 5'h13, 5'h01, 5'h02};
		step(1);
		planeSop = 4'h2;
		chk(busSop, 4'hC);
		chk({stamp[63], stamp[62:16], stamp[15:0]}, {1'b1, 47'h1234_5678, 16'hABCD});
		chk(laneIdx, 5'h13);
		chk(captureTransparent, 1'b1);
		step(1);
		planeSop = 4'h0;
		chk(busSop, 4'h2);
		chk(stamp[62:0], {47'h1234_56AA, 16'hABCD});
		chk(laneIdx, 5'h01);
		transparentMode = 1'b0;
	endtask

	task automatic fillLevels;
		alignWr = 20'h00008;
		step(3);
		alignWr = 20'h00000;
		alignRd = 20'h00008;
		step(1);
		alignWr = 20'h00008;
		step(1);
		alignWr = 20'h00000;
		alignRd = 20'h80000;
		step(1);
		alignRd = 20'h00000;
		alignWr = 20'h00001;
		step(130);
		alignWr = 20'h00000;
		step(1);
		chk(fill[3*7+:7], 7'h02);
		chk(fill[19*7+:7], 7'h00);
		chk(fill[6:0], 7'h7F);
		loadTime(80'h1000);
		planeSop = 4'h1;
		planeLane = 20'h00003;
		step(1);
		planeSop = 4'h0;
		step(1);
		chk(corrected, 80'h1002);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		end_sim();
	end
	initial begin
		{nrst, transparentMode, loadEn, planeSop, planeLane, alignWr, alignRd} = '0;
		loadVal = 80'h0;
		step(12);
		nrst = 1'b1;
		chk({stamp, laneIdx, captureHeld}, 86'h0);
		chk(fill, 140'h0);
		capNormal();
		capTransparent();
		fillLevels();
		nrst = 1'b0;
		step(1);
		chk({stamp, laneIdx, busSop, captureHeld, captureTransparent}, 91'h0);
		chk(fill, 140'h0);
		nrst = 1'b1;
		step(2);
		chk({stamp, laneIdx, busSop, captureHeld}, 90'h0);
		capNormal();
		end_sim();
	end
endmodule
